// ===== logic/mss_top.sv
// Multi-step setpoint sequencer with its AXI4-Lite register file.
// What this block does
// - Sixteen signed step commands, limited to plus or minus 100.0 percent, reset zero.
// - As frequency reference a command is a percentage of maximum frequency.
// - As process PID reference the command passes through unscaled.
// - Digital terminal states pick which of the sixteen commands is active.
// - The sequencer serves as frequency reference or as V/F voltage reference.
// - As frequency reference, negative segment commands run the motor in reverse, positive ones forward.
// - Mode 0 stops after one pass; only a new run restarts it.
// - Mode 1 keeps the last segment's frequency and direction after one pass.
// - Mode 2 repeats the pass until a stop command arrives.
// - End modes apply only as frequency reference, not as voltage reference.
// - Power retention keeps segment across power loss; otherwise sequence restarts.
// - Stop retention resumes from the stopped segment; otherwise each run restarts.
// - Each segment has a run time 0.0 to 6553.5 in seconds or hours.
// - Each segment has a ramp selector 0 to 3 used while it runs.
// - There are sixteen segments numbered zero to fifteen.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mss_top #(
  parameter int TENTH_CYCLES = mss_pkg::TENTH_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite write channels.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Step selection terminals.
  input  wire logic [3:0]  step_terminals,
  // Setpoint outputs.
  output logic             run_active,
  output logic [15:0]      freq_ref,
  output logic             reverse,
  output logic [15:0]      volt_ref,
  output logic [15:0]      pid_ref,
  output logic [1:0]       ramp_select,
  output logic [3:0]       segment
);
  import mss_pkg::*;

  // Parameter store and control state.
  logic [15:0] cmd_val  [NUM_STEPS];
  logic [15:0] seg_dur  [NUM_STEPS];
  logic [1:0]  seg_ramp [NUM_STEPS];
  logic [1:0]  end_mode;
  logic [1:0]  retain;
  logic [15:0] max_freq;
  logic        as_volt;
  logic        hours;
  logic        term_sel;
  mss_state_t  state;
  logic [3:0]  seg_idx;
  logic [3:0]  resume_seg;
  logic        resume_ok;
  logic        ran_in_pass;
  logic        pass_done;
  logic [3:0]  last_ran;
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic [3:0]  strb_q;

  mss_seg_if seg_if ();

  mss_seg_timer #(.TENTH_CYCLES(TENTH_CYCLES)) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .seg   (seg_if)
  );

  mss_scaler u_scaler (
    .clk   (clk),
    .rst_n (rst_n),
    .seg   (seg_if)
  );

  // Word decode shared by both bus directions.
  function automatic logic [31:0] reg_read(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[11:6] == OFS_CMD[11:6]) begin
      v = {{16{cmd_val[a[5:2]][15]}}, cmd_val[a[5:2]]};
    end else if (a[11:6] == OFS_SEG[11:6]) begin
      v = {14'h0000, seg_ramp[a[5:2]], seg_dur[a[5:2]]};
    end else if (a == OFS_CTRL) begin
      v = {26'h0000000, term_sel, 1'b0, hours, as_volt, 2'h0};
    end else if (a == OFS_MODE) begin
      v = {30'h00000000, end_mode};
    end else if (a == OFS_RETAIN) begin
      v = {30'h00000000, retain};
    end else if (a == OFS_MAXF) begin
      v = {16'h0000, max_freq};
    end else if (a == OFS_STATUS) begin
      v = {24'h000000, pass_done, reverse, run_active, 1'b0, segment};
    end else if (a == OFS_SETPT) begin
      v = {16'h0000, freq_ref};
    end
    return v;
  endfunction : reg_read

  // Whether an aligned address holds a register.
  function automatic logic reg_hit(input logic [11:0] a);
    return (a[1:0] == 2'h0) && ((a[11:6] == OFS_CMD[11:6]) || (a[11:6] == OFS_SEG[11:6])
      || (a == OFS_CTRL) || (a == OFS_MODE) || (a == OFS_RETAIN) || (a == OFS_MAXF)
      || (a == OFS_STATUS) || (a == OFS_SETPT));
  endfunction : reg_hit

  // Write path: address and data are taken in either order, then one response.
  wire        wr_go   = aw_held && w_held && !s_axi_bvalid;
  wire [31:0] wmask   = {{8{strb_q[3]}}, {8{strb_q[2]}}, {8{strb_q[1]}}, {8{strb_q[0]}}};
  wire [31:0] wr_val  = (reg_read(aw_q) & ~wmask) | (w_q & wmask);
  wire        wr_ok   = wr_go && reg_hit(aw_q);
  wire        wr_cmd  = wr_ok && (aw_q[11:6] == OFS_CMD[11:6]);
  wire        wr_seg  = wr_ok && (aw_q[11:6] == OFS_SEG[11:6]);
  wire        wr_ctrl = wr_ok && (aw_q == OFS_CTRL);
  wire        run_p   = wr_ctrl && strb_q[0] && w_q[CTRL_RUN];
  wire        stop_p  = wr_ctrl && strb_q[0] && w_q[CTRL_STOP];
  wire        power_p = wr_ctrl && strb_q[0] && w_q[CTRL_POWER];
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Holding registers of the two write channels.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 12'h000;
      w_q     <= 32'h0000_0000;
      strb_q  <= 4'h0;
    end else begin
      aw_held <= wr_go ? 1'b0 : (aw_held || s_axi_awvalid);
      w_held  <= wr_go ? 1'b0 : (w_held || s_axi_wvalid);
      aw_q    <= s_axi_awvalid && !aw_held ? s_axi_awaddr : aw_q;
      w_q     <= s_axi_wvalid && !w_held ? s_axi_wdata : w_q;
      strb_q  <= s_axi_wvalid && !w_held ? s_axi_wstrb : strb_q;
    end
  end

  // Write and read responses.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      s_axi_bvalid <= wr_go || (s_axi_bvalid && !s_axi_bready);
      s_axi_bresp  <= wr_go ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : s_axi_bresp;
      s_axi_rvalid <= (s_axi_arvalid && !s_axi_rvalid) || (s_axi_rvalid && !s_axi_rready);
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rdata <= reg_hit(s_axi_araddr) ? reg_read(s_axi_araddr) : 32'h0000_0000;
        s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Step command and segment tables.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_STEPS; i++) begin
        cmd_val[i]  <= CMD_RESET;
        seg_dur[i]  <= DUR_RESET;
        seg_ramp[i] <= RAMP_RESET;
      end
    end else begin
      if (wr_cmd) begin
        cmd_val[aw_q[5:2]] <= mss_clamp(wr_val[15:0]);
      end
      if (wr_seg) begin
        seg_dur[aw_q[5:2]]  <= wr_val[15:0];
        seg_ramp[aw_q[5:2]] <= wr_val[SEG_RAMP_LSB+1:SEG_RAMP_LSB];
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      end_mode <= END_STOP;
      retain   <= 2'h0;
      max_freq <= MAXF_RESET;
      as_volt  <= 1'b0;
      hours    <= 1'b0;
      term_sel <= 1'b0;
    end else begin
      if (wr_ok && aw_q == OFS_MODE && wr_val[1:0] != 2'h3) begin
        end_mode <= wr_val[1:0];
      end
      if (wr_ok && aw_q == OFS_RETAIN) begin
        retain <= wr_val[1:0];
      end
      if (wr_ok && aw_q == OFS_MAXF) begin
        max_freq <= wr_val[15:0];
      end
      if (wr_ctrl) begin
        as_volt  <= wr_val[CTRL_VOLT];
        hours    <= wr_val[CTRL_HOURS];
        term_sel <= wr_val[CTRL_TERM];
      end
    end
  end

  // Sequencer decisions for the segment now being looked at.
  wire        at_last  = (seg_idx == 4'hF);
  wire        zero_dur = (seg_dur[seg_idx] == 16'h0000);
  wire        pass_end = (state == MSS_LOAD && zero_dur && at_last)
                      || (state == MSS_RUN && seg_if.expired && at_last);
  wire        any_ran  = ran_in_pass || (state == MSS_RUN);
  wire [3:0]  start_seg = resume_ok ? resume_seg : 4'h0;
  wire        do_hold  = !as_volt && end_mode == END_HOLD;
  wire        do_loop  = as_volt || end_mode == END_LOOP;

  // Next state of the sequencer.
  mss_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      MSS_IDLE: begin
        if (run_p && !stop_p) begin
          next_state = MSS_LOAD;
        end
      end
      MSS_LOAD: begin
        if (pass_end && !any_ran) begin
          next_state = MSS_IDLE;
        end else if (pass_end) begin
          next_state = do_hold ? MSS_HOLD : (do_loop ? MSS_LOAD : MSS_IDLE);
        end else if (!zero_dur) begin
          next_state = MSS_RUN;
        end
      end
      MSS_RUN: begin
        if (pass_end) begin
          next_state = do_hold ? MSS_HOLD : (do_loop ? MSS_LOAD : MSS_IDLE);
        end else if (seg_if.expired) begin
          next_state = MSS_LOAD;
        end
      end
      default: begin
        next_state = MSS_HOLD;
      end
    endcase
    if (stop_p || power_p) begin
      next_state = MSS_IDLE;
    end
  end

  // Segment index, pass bookkeeping and retained position.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state       <= MSS_IDLE;
      seg_idx     <= 4'h0;
      resume_seg  <= 4'h0;
      resume_ok   <= 1'b0;
      ran_in_pass <= 1'b0;
      pass_done   <= 1'b0;
      last_ran    <= 4'h0;
    end else begin
      state <= next_state;
      // Remembers the last segment that really ran, so a hold skips trailing empties.
      if (state == MSS_RUN) begin
        last_ran <= seg_idx;
      end
      if (stop_p && state != MSS_IDLE) begin
        resume_seg <= seg_idx;
        resume_ok  <= retain[RET_STOP];
      end else if (power_p) begin
        resume_seg <= state != MSS_IDLE ? seg_idx : resume_seg;
        resume_ok  <= retain[RET_POWER] && (state != MSS_IDLE || resume_ok);
      end else if (state == MSS_IDLE && next_state == MSS_LOAD) begin
        resume_ok  <= 1'b0;
      end
      if (state == MSS_IDLE && next_state == MSS_LOAD) begin
        seg_idx     <= start_seg;
        ran_in_pass <= 1'b0;
        pass_done   <= 1'b0;
      end else if (pass_end && next_state == MSS_LOAD) begin
        seg_idx     <= 4'h0;
        ran_in_pass <= 1'b0;
      end else if (pass_end) begin
        pass_done   <= 1'b1;
        seg_idx     <= (state == MSS_RUN) ? seg_idx : last_ran;
      end else if (state == MSS_LOAD && zero_dur) begin
        seg_idx     <= seg_idx + 4'h1;
      end else if (state == MSS_RUN && seg_if.expired) begin
        seg_idx     <= seg_idx + 4'h1;
        ran_in_pass <= 1'b1;
      end
    end
  end

  // Timer and scaler hookup; the active command is from terminals or the sequencer.
  wire [3:0]  act_idx = term_sel ? step_terminals : seg_idx;
  wire        seq_on  = (state == MSS_RUN) || (state == MSS_HOLD);
  wire        out_on  = term_sel || seq_on;
  assign seg_if.load     = (state == MSS_LOAD) && !zero_dur;
  assign seg_if.duration = seg_dur[seg_idx];
  assign seg_if.hours    = hours;
  assign seg_if.cmd      = cmd_val[act_idx];
  assign seg_if.max_freq = max_freq;

  // Registered setpoint outputs; the references are zero while nothing drives them, ramp and segment always follow.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_active  <= 1'b0;
      freq_ref    <= 16'h0000;
      reverse     <= 1'b0;
      volt_ref    <= 16'h0000;
      pid_ref     <= 16'h0000;
      ramp_select <= 2'h0;
      segment     <= 4'h0;
    end else begin
      run_active  <= seq_on;
      freq_ref    <= out_on && !as_volt ? seg_if.freq_mag : 16'h0000;
      reverse     <= out_on && !as_volt && seg_if.reverse;
      volt_ref    <= out_on && as_volt ? cmd_val[act_idx] : 16'h0000;
      pid_ref     <= out_on ? cmd_val[act_idx] : 16'h0000;
      ramp_select <= seg_ramp[act_idx];
      segment     <= act_idx;
    end
  end

  // Checks on the sequencer and the register file.
  a_cmd_clamped: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cmd |=> $signed(cmd_val[$past(aw_q[5:2])]) <= $signed(CMD_LIMIT)
    && $signed(cmd_val[$past(aw_q[5:2])]) >= -$signed(CMD_LIMIT))
    else $error("Step command left the 100 percent range.");
  a_pid_unscaled: assert property (@(posedge clk) disable iff (!rst_n)
    out_on && !wr_cmd |=> pid_ref == $past(cmd_val[act_idx]))
    else $error("Process reference differs from the command.");
  a_term_select: assert property (@(posedge clk) disable iff (!rst_n)
    term_sel |=> segment == $past(step_terminals))
    else $error("Active step does not follow the terminals.");
  a_volt_no_freq: assert property (@(posedge clk) disable iff (!rst_n)
    as_volt |=> freq_ref == 16'h0000 && !reverse)
    else $error("Frequency driven while in voltage mode.");
  a_reverse_sign: assert property (@(posedge clk) disable iff (!rst_n)
    reverse |-> $past(out_on) && !$past(as_volt))
    else $error("Reverse asserted with no frequency source.");
  a_stop_at_end: assert property (@(posedge clk) disable iff (!rst_n)
    pass_end && !as_volt && end_mode == END_STOP && !stop_p |=> state == MSS_IDLE)
    else $error("Mode 0 did not stop at end of pass.");
  a_hold_at_end: assert property (@(posedge clk) disable iff (!rst_n)
    state == MSS_HOLD && !stop_p && !power_p |=> state == MSS_HOLD && $stable(seg_idx))
    else $error("Held segment changed without a stop.");
  a_loop_restart: assert property (@(posedge clk) disable iff (!rst_n)
    pass_end && do_loop && any_ran && !stop_p && !power_p
    |=> seg_idx == 4'h0 && state == MSS_LOAD)
    else $error("Looping pass did not restart at segment zero.");
  a_stop_resume: assert property (@(posedge clk) disable iff (!rst_n)
    stop_p && state == MSS_RUN |=> resume_ok == retain[RET_STOP] && resume_seg == $past(seg_idx))
    else $error("Stop retention not recorded.");
  a_power_forget: assert property (@(posedge clk) disable iff (!rst_n)
    power_p && !retain[RET_POWER] |=> !resume_ok)
    else $error("Position kept across power loss without retention.");
  a_skip_zero: assert property (@(posedge clk) disable iff (!rst_n)
    state == MSS_LOAD && zero_dur && !at_last && !stop_p && !power_p
    |=> seg_idx == $past(seg_idx) + 4'h1 && state == MSS_LOAD)
    else $error("Zero-time segment was not skipped.");
  a_ramp_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_seg |=> ramp_select == $past(seg_ramp[act_idx]))
    else $error("Ramp set does not follow the segment.");
  c_full_pass: cover property (@(posedge clk) disable iff (!rst_n) pass_end && any_ran);
  c_hold: cover property (@(posedge clk) disable iff (!rst_n) state == MSS_HOLD);
  c_resume: cover property (@(posedge clk) disable iff (!rst_n) run_p && resume_ok);
  c_reverse: cover property (@(posedge clk) disable iff (!rst_n) reverse && run_active);
endmodule : mss_top
`default_nettype wire

// ===== logic/mss_pkg.sv
// Shared constants, register map and types of the multi-step setpoint sequencer.
package mss_pkg;
  // Clock rate and the tenth-of-a-unit time base.
  localparam int          CLK_PERIOD_NS = 5;
  localparam longint      TENTH_SEC_NS  = 64'h0000_0000_05F5_E100; // 0.1 s in ns.
  localparam int          TENTH_CYCLES  = int'(TENTH_SEC_NS / CLK_PERIOD_NS);
  localparam logic [11:0] TENTHS_PER_TENTH_HOUR = 12'hE10; // 0.1 h is 3600 tenths of a second.
  // Step commands in tenths of a percent.
  localparam int          NUM_STEPS  = 16;
  localparam logic [15:0] CMD_LIMIT  = 16'h03E8; // 100.0 %.
  localparam logic [15:0] CMD_RESET  = 16'h0000;
  localparam logic [15:0] DUR_RESET  = 16'h0000;
  localparam logic [1:0]  RAMP_RESET = 2'h0;
  localparam logic [15:0] MAXF_RESET = 16'h1388; // 50.00 Hz in 0.01 Hz units.
  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_MODE   = 12'h004;
  localparam logic [11:0] OFS_RETAIN = 12'h008;
  localparam logic [11:0] OFS_MAXF   = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_SETPT  = 12'h014;
  localparam logic [11:0] OFS_CMD    = 12'h040;
  localparam logic [11:0] OFS_SEG    = 12'h080;
  // Control register fields.
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_STOP  = 1;
  localparam int CTRL_VOLT  = 2;
  localparam int CTRL_HOURS = 3;
  localparam int CTRL_POWER = 4;
  localparam int CTRL_TERM  = 5;
  // Retention select digits and segment ramp field.
  localparam int RET_POWER  = 0;
  localparam int RET_STOP   = 1;
  localparam int SEG_RAMP_LSB = 16;
  // End-of-sequence modes and bus responses.
  localparam logic [1:0] END_STOP = 2'h0;
  localparam logic [1:0] END_HOLD = 2'h1;
  localparam logic [1:0] END_LOOP = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MSS_IDLE, MSS_LOAD, MSS_RUN, MSS_HOLD} mss_state_t;
  // Limits a written command to plus or minus 100.0 percent.
  function automatic logic [15:0] mss_clamp(input logic [15:0] v);
    if ($signed(v) > $signed(CMD_LIMIT)) begin
      return CMD_LIMIT;
    end else if ($signed(v) < -$signed(CMD_LIMIT)) begin
      return 16'(-$signed(CMD_LIMIT));
    end
    return v;
  endfunction : mss_clamp
endpackage : mss_pkg

// ===== logic/mss_seg_if.sv
// Carrier between the sequencer core, its segment timer and its scaler.
`timescale 1ns/1ps
`default_nettype none
interface mss_seg_if;
  logic        load;
  logic [15:0] duration;
  logic        hours;
  logic        expired;
  logic [15:0] cmd;
  logic [15:0] max_freq;
  logic [15:0] freq_mag;
  logic        reverse;
  modport core   (output load, duration, hours, cmd, max_freq, input expired, freq_mag, reverse);
  modport timer  (input load, duration, hours, output expired);
  modport scaler (input cmd, max_freq, output freq_mag, reverse);
endinterface : mss_seg_if
`default_nettype wire

// ===== logic/mss_seg_timer.sv
// Segment run-time counter in tenths of a second or tenths of an hour.
`timescale 1ns/1ps
`default_nettype none
module mss_seg_timer #(
  parameter int TENTH_CYCLES = mss_pkg::TENTH_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the core.
  mss_seg_if.timer seg
);
  import mss_pkg::*;
  logic [31:0] pre;
  logic [11:0] sub;
  logic [15:0] tenths;
  // A tenth-second tick, and a tenth-hour tick every 3600 of them.
  wire sec_tick  = (pre == 32'(TENTH_CYCLES - 1));
  wire sub_end   = (sub == TENTHS_PER_TENTH_HOUR - 12'h001);
  wire unit_tick = sec_tick && (!seg.hours || sub_end);
  wire last      = unit_tick && (tenths + 16'h0001 == seg.duration);
  // Counting restarts on every load so a segment gets its full time.
  always_ff @(posedge clk) begin
    if (!rst_n || seg.load) begin
      pre         <= 32'h0000_0000;
      sub         <= 12'h000;
      tenths      <= 16'h0000;
      seg.expired <= 1'b0;
    end else begin
      pre         <= sec_tick ? 32'h0000_0000 : pre + 32'h0000_0001;
      sub         <= !sec_tick ? sub : (sub_end ? 12'h000 : sub + 12'h001);
      tenths      <= unit_tick ? tenths + 16'h0001 : tenths;
      seg.expired <= last;
    end
  end
endmodule : mss_seg_timer
`default_nettype wire

// ===== logic/mss_scaler.sv
// Turns a signed step command into a frequency magnitude and a direction.
`timescale 1ns/1ps
`default_nettype none
module mss_scaler (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the core.
  mss_seg_if.scaler seg
);
  import mss_pkg::*;
  // Magnitude of the command times maximum frequency, over 100.0 percent.
  wire        neg  = seg.cmd[15];
  wire [15:0] mag  = neg ? 16'(-seg.cmd) : seg.cmd;
  wire [31:0] prod = 32'(mag) * 32'(seg.max_freq);
  wire [31:0] quo  = prod / 32'(CMD_LIMIT);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seg.freq_mag <= 16'h0000;
      seg.reverse  <= 1'b0;
    end else begin
      seg.freq_mag <= quo[15:0];
      seg.reverse  <= neg;
    end
  end
endmodule : mss_scaler
`default_nettype wire

// ===== test/mss_term_model.sv
// Stand-in for the drive's multi-function step selection terminals.
`timescale 1ns/1ps
`default_nettype none
module mss_term_model (
  // Clock.
  input  wire logic       clk,
  // Requested step index and the terminal levels it produces.
  input  wire logic [3:0] sel,
  output logic      [3:0] step_terminals
);
  // Terminals settle just after an edge, as a filtered input would.
  initial step_terminals = 4'h0;
  always @(posedge clk) begin
    step_terminals <= sel;
  end
endmodule : mss_term_model
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the multi-step setpoint sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mss_pkg::*;
  localparam int TC = 4;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, sel = 4'h0, step_terminals, segment;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        run_active, reverse;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ramp_select;
  logic [15:0] freq_ref, volt_ref, pid_ref;
  logic [33:0] exp_q[$];
  int          failures = 0, comparisons = 0;

  mss_top #(.TENTH_CYCLES(TC)) mss_top_inst (.*);
  mss_term_model mss_term_model_inst (.clk(clk), .sel(sel), .step_terminals(step_terminals));

  // Clock of 5 ns period.
  initial forever #2.5 clk = ~clk;

  // Compares one result and counts it.
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus write; both channels are offered together and held until taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Bus read; the expected response and data are queued for the monitor.
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Monitor takes the oldest note whenever read data is handed over.
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
  end

  // Waits, bounded, until the sequencer runs the given segment.
  task automatic wait_seg(input logic [3:0] s);
    int n = 0;
    while (!(segment === s && run_active === 1'b1) && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(34'(n < 500), 34'h1);
    repeat (3) @(posedge clk);
  endtask : wait_seg

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("Counts: comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end

  // Main sequence of tests.
  initial begin
    logic [15:0] v;
    logic [3:0]  k;
    logic [1:0]  r;
    void'($urandom(32'h52E8));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CMD, '0);
    rd(OFS_MAXF, 34'(MAXF_RESET));
    rd(12'hFFC, {RESP_SLVERR, 32'h0});
    wr(OFS_CMD + 12'h14, 32'h7D0);
    rd(OFS_CMD + 12'h14, 34'(CMD_LIMIT));
    wr(OFS_CMD + 12'h18, 32'hF830);
    rd(OFS_CMD + 12'h18, 34'h0FFFFFC18);
    $display("Test registers done");
    wr(OFS_MAXF, 32'h3E8);
    repeat (4) begin
      k = 4'($urandom);
      v = 16'($urandom_range(2000) - 1000);
      r = 2'($urandom);
      wr(OFS_CMD + 12'(k) * 12'h4, 32'(v));
      wr(OFS_SEG + 12'(k) * 12'h4, {14'h0, r, 16'h0});
      wr(OFS_CTRL, 32'h20);
      sel <= k;
      repeat (5) @(posedge clk);
      chk(34'(segment), 34'(k));
      chk(34'(pid_ref), 34'(v));
      chk(34'(freq_ref), 34'(16'($signed(v) < 0 ? -v : v)));
      chk(34'(reverse), 34'($signed(v) < 0));
      chk(34'(ramp_select), 34'(r));
      wr(OFS_CTRL, 32'h24);
      repeat (5) @(posedge clk);
      chk(34'(volt_ref), 34'(v));
      chk(34'(freq_ref), 34'h0);
    end
    $display("Test terminals done");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CMD, 32'h12C);
    wr(OFS_SEG, 32'h1);
    wr(OFS_CMD + 12'h8, 32'hFE0C);
    wr(OFS_SEG + 12'h8, 32'h5);
    for (int m = 0; m < 3; m++) begin
      wr(OFS_MODE, 32'(m));
      wr(OFS_CTRL, 32'h1);
      wait_seg(4'h2);
      chk(34'(reverse), 34'h1);
      chk(34'(freq_ref), 34'h1F4);
      repeat (100) @(posedge clk);
      chk(34'(run_active), 34'(m != 0));
      if (m == 1) chk(34'(segment), 34'h2);
      wr(OFS_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk(34'(run_active), 34'h0);
      $display("Test end mode %0d done", m);
    end
    wr(OFS_MODE, 32'h0);
    wr(OFS_CTRL, 32'h9);
    repeat (100) @(posedge clk);
    chk(34'(run_active), 34'h1);
    chk(34'(segment), 34'h0);
    wr(OFS_CTRL, 32'h2);
    $display("Test hour unit done");
    for (int i = 1; i < 3; i++) begin
      wr(OFS_RETAIN, 32'(i));
      wr(OFS_CTRL, 32'h1);
      wait_seg(4'h2);
      wr(OFS_CTRL, i == 1 ? 32'h10 : 32'h2);
      wr(OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk(34'(segment), 34'h2);
      wr(OFS_CTRL, 32'h2);
      $display("Test retention %0d done", i);
    end
    final_report;
  end
endmodule : testbench
`default_nettype wire
